// ### design/fgw_pkg.sv
package fgw_pkg;
  // Timing base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // Blink code timing in milliseconds
  localparam int BLINK_ON_MS = 250;
  localparam int BLINK_GAP_MS = 250;
  localparam int BLINK_PAUSE_MS = 1000;
  // Link-loss fault and substitute input words
  localparam logic [7:0] LINK_FAULT_CODE = 8'h5b;
  localparam int MALFUNC_POS = 5;
  localparam logic [15:0] WORD_ONE_LOST = 16'h5b20;
  localparam logic [15:0] WORD_TWO_LOST = 16'h0000;
  localparam logic [15:0] WORD_THREE_LOST = 16'h0020;
  // Expected packet rate attribute
  localparam logic [7:0] EPR_CLASS = 8'h05;
  localparam logic [7:0] EPR_ATTR = 8'h09;
  localparam int EPR_STEP_MS = 5;
  localparam int TIMEOUT_MULT = 4;
  localparam logic [15:0] EPR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CODE_OFF = 2'h0,
    CODE_ONE = 2'h1,
    CODE_TWO = 2'h2,
    CODE_STEADY = 2'h3
  } fgw_code_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PULSE = 4'h2,
    ST_GAP = 4'h4,
    ST_PAUSE = 4'h8
  } fgw_blink_e;
endpackage : fgw_pkg

// ### design/fgw_blink_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fgw_blink_if;
  import fgw_pkg::*;
  fgw_code_e code;
  logic mute;
  logic msTick;
  logic led;
  modport ctrl (output code, output mute, output msTick, input led);
  modport gen (input code, input mute, input msTick, output led);
endinterface : fgw_blink_if
`default_nettype wire

// ### design/fgw_blink_gen.sv
`timescale 1ns/1ps
`default_nettype none
module fgw_blink_gen
  import fgw_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // Code in, indicator out
  fgw_blink_if.gen blink
);
  fgw_blink_e state, next_state;
  logic [9:0] cnt, next_cnt;
  logic left, next_left;
  logic next_led;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_left = left;
    case (state)
      ST_IDLE: begin
        if (blink.code == CODE_ONE || blink.code == CODE_TWO) begin
          next_state = ST_PULSE;
          next_cnt = 10'h000;
          next_left = (blink.code == CODE_TWO);
        end
      end
      ST_PULSE: begin
        if (blink.msTick) begin
          if (cnt == 10'(BLINK_ON_MS - 1)) begin
            next_state = ST_GAP;
            next_cnt = 10'h000;
          end else begin
            next_cnt = cnt + 10'h001;
          end
        end
      end
      ST_GAP: begin
        if (blink.msTick) begin
          if (cnt == 10'(BLINK_GAP_MS - 1)) begin
            next_cnt = 10'h000;
            next_state = left ? ST_PULSE : ST_PAUSE;
            next_left = 1'b0;
          end else begin
            next_cnt = cnt + 10'h001;
          end
        end
      end
      ST_PAUSE: begin
        // Dark pause separates one code cycle from the next
        if (blink.msTick) begin // RL16
          if (cnt == 10'(BLINK_PAUSE_MS - 1)) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt + 10'h001;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Steady and muted cut any running code at once
    if (blink.mute || blink.code == CODE_STEADY) begin
      next_state = ST_IDLE;
      next_cnt = 10'h000;
      next_left = 1'b0;
    end
    next_led = !blink.mute
      && (blink.code == CODE_STEADY || next_state == ST_PULSE);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= 10'h000;
      left <= 1'b0;
      blink.led <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      cnt <= next_cnt;
      left <= next_left;
      blink.led <= next_led;
    end
  end

  pauseDark_a: assert property (@(posedge ref_clk) disable iff (rst) // RL16
    state == ST_PAUSE |-> !blink.led)
    else $error("indicator lit during pause");
  pauseSeen_c: cover property (@(posedge ref_clk) disable iff (rst)
    state == ST_GAP ##1 state == ST_PAUSE);
endmodule : fgw_blink_gen
`default_nettype wire

// ### design/fgw_fault_status.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RL1] Indicator dark while gateway and inverter run normally.
// [RL2] One blink per cycle on inverter fault; code readable in word one.
// [RL3] Two blinks per cycle when inverter ignores setpoints, outputs disabled.
// [RL4] Indicator steady while the serial inverter link is lost.
// [RL5] Indicator steady while the maintenance switch is off.
// [RL6] Link loss reports fault code 91 on diagnostics and status words.
// [RL7] Link-loss fault ignores control-word reset, clears when link returns.
// [RL8] Link loss returns fixed words 5B20, 0000, 0020.
// [RL9] Fault code in upper byte of word one, malfunction bit 5 set.
// [RL10] Digital input byte keeps updating during link loss.
// [RL11] Master sets the timeout interval after connection is established.
// [RL12] Fieldbus timeout fires after four times the expected packet rate.
// [RL13] Packet rate 5 to 65535 ms in 5 ms steps; zero disables.
// [RL14] Packet rate written through class 0x05, attribute 0x09.
// [RL15] Indicator has no function with zero process words configured.
// [RL16] Each blink code cycle ends with a dark pause.
module fgw_fault_status
  import fgw_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // Inverter serial link receiver
  input wire logic linkUp,
  input wire logic invFault,
  input wire logic invOutputsEnabled,
  input wire logic [15:0] invWordOne,
  input wire logic [15:0] invWordTwo,
  input wire logic [15:0] invWordThree,
  // Field pins
  input wire logic maintSwitchOff,
  input wire logic [7:0] digitalInputPins,
  input wire logic [3:0] processWords,
  // Fieldbus master side
  input wire logic ctrlResetReq,
  input wire logic packetRx,
  input wire logic eprWrite,
  input wire logic [7:0] eprClass,
  input wire logic [7:0] eprAttr,
  input wire logic [15:0] eprValue,
  // Indicator
  output logic sysFaultIndicator,
  // Process input data and diagnostics
  output logic [15:0] processInputWordOne,
  output logic [15:0] processInputWordTwo,
  output logic [15:0] processInputWordThree,
  output logic [7:0] digitalInputByte,
  output logic [7:0] diagFaultCode,
  output logic linkFault,
  output logic inverterResetReq,
  // Packet rate and timeout
  output logic eprAck,
  output logic eprReject,
  output logic [15:0] expectedPacketRate,
  output logic busTimeout
);
  localparam int PW = $clog2(MS_TICKS);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Pin synchronisers
  logic maintMeta, maintSync;
  logic [7:0] diMeta, diSync;
  logic [3:0] pwMeta, pwSync;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      maintMeta <= 1'b0;
      maintSync <= 1'b0;
      diMeta <= 8'h00;
      diSync <= 8'h00;
      pwMeta <= 4'h0;
      pwSync <= 4'h0;
    end else if (clkEn) begin
      maintMeta <= maintSwitchOff;
      maintSync <= maintMeta;
      diMeta <= digitalInputPins;
      diSync <= diMeta;
      pwMeta <= processWords;
      pwSync <= pwMeta;
    end
  end

  // Millisecond prescaler
  logic [PW-1:0] preCnt, next_preCnt;
  logic msTick;

  assign msTick = (preCnt == PW'(MS_TICKS - 1));

  always_comb begin
    next_preCnt = msTick ? '0 : preCnt + 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      preCnt <= '0;
    end else if (clkEn) begin
      preCnt <= next_preCnt;
    end
  end

  // Link-loss fault and process input data
  logic next_linkFault, next_inverterResetReq;
  logic [15:0] next_wordOne, next_wordTwo, next_wordThree;
  logic [7:0] next_diByte, next_diag;

  always_comb begin
    // Follows the link only; control-word reset has no say
    next_linkFault = !linkUp; // RL7
    // Reset reaches the inverter only while the link works
    next_inverterResetReq = ctrlResetReq && !linkFault; // RL7
    if (linkFault) begin
      next_wordOne = WORD_ONE_LOST; // RL8 RL9
      next_wordTwo = WORD_TWO_LOST; // RL8
      next_wordThree = WORD_THREE_LOST; // RL8 RL9
      next_diag = LINK_FAULT_CODE; // RL6
    end else begin
      next_wordOne = invWordOne; // RL2
      next_wordTwo = invWordTwo;
      next_wordThree = invWordThree;
      next_diag = invFault ? invWordOne[15:8] : 8'h00;
    end
    next_diByte = diSync; // RL10
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      linkFault <= 1'b0;
      inverterResetReq <= 1'b0;
      processInputWordOne <= 16'h0000;
      processInputWordTwo <= 16'h0000;
      processInputWordThree <= 16'h0000;
      diagFaultCode <= 8'h00;
      digitalInputByte <= 8'h00;
    end else if (clkEn) begin
      linkFault <= next_linkFault;
      inverterResetReq <= next_inverterResetReq;
      processInputWordOne <= next_wordOne;
      processInputWordTwo <= next_wordTwo;
      processInputWordThree <= next_wordThree;
      diagFaultCode <= next_diag;
      digitalInputByte <= next_diByte;
    end
  end

  // Indicator code selection
  fgw_blink_if blink ();
  fgw_code_e code;

  always_comb begin
    if (linkFault || maintSync) begin
      code = CODE_STEADY; // RL4 RL5
    end else if (!invOutputsEnabled) begin
      code = CODE_TWO; // RL3
    end else if (invFault) begin
      code = CODE_ONE; // RL2
    end else begin
      code = CODE_OFF; // RL1
    end
  end

  assign blink.code = code;
  assign blink.mute = (pwSync == 4'h0); // RL15
  assign blink.msTick = msTick;
  assign sysFaultIndicator = blink.led;

  fgw_blink_gen u_blink (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .blink(blink)
  );

  // Expected packet rate and fieldbus timeout
  logic [15:0] next_epr;
  logic next_eprAck, next_eprReject, next_busTimeout;
  // Wide enough for four times the largest rate
  logic [17:0] tmoCnt, next_tmoCnt, tmoLimit;
  logic eprHit;

  assign eprHit = (eprClass == EPR_CLASS) && (eprAttr == EPR_ATTR); // RL14
  assign tmoLimit = 18'(expectedPacketRate) * 18'(TIMEOUT_MULT); // RL12

  always_comb begin
    next_epr = expectedPacketRate;
    next_eprAck = 1'b0;
    next_eprReject = 1'b0;
    next_tmoCnt = tmoCnt;
    next_busTimeout = busTimeout;
    // Master writes this once the connection stands
    if (eprWrite) begin // RL11
      if (eprHit && eprValue % 16'(EPR_STEP_MS) == 16'h0000) begin // RL13
        next_epr = eprValue; // RL14
        next_eprAck = 1'b1;
      end else begin
        next_eprReject = 1'b1;
      end
    end
    if (packetRx || eprWrite) begin
      next_tmoCnt = 18'h00000;
      next_busTimeout = 1'b0;
    end else if (msTick && !busTimeout) begin
      next_tmoCnt = tmoCnt + 18'h00001;
    end
    // Expiry in the cycle of a packet still wins
    if (expectedPacketRate != 16'h0000 && !busTimeout
        && tmoCnt >= tmoLimit) begin
      next_busTimeout = 1'b1; // RL12 RL13
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      expectedPacketRate <= EPR_RESET;
      eprAck <= 1'b0;
      eprReject <= 1'b0;
      tmoCnt <= 18'h00000;
      busTimeout <= 1'b0;
    end else if (clkEn) begin
      expectedPacketRate <= next_epr;
      eprAck <= next_eprAck;
      eprReject <= next_eprReject;
      tmoCnt <= next_tmoCnt;
      busTimeout <= next_busTimeout;
    end
  end

  // Rule checks sample every edge; those with clkEn in the antecedent start only on enabled edges, and |=> steps to the next edge
  darkNormal_a: assert property ( // RL1
    !linkFault && !maintSync && invOutputsEnabled && !invFault
    |-> code == CODE_OFF)
    else $error("indicator code not off in normal state");
  oneBlink_a: assert property ( // RL2
    !linkFault && !maintSync && invOutputsEnabled && invFault
    |-> code == CODE_ONE)
    else $error("inverter fault not shown as one blink");
  twoBlink_a: assert property ( // RL3
    !linkFault && !maintSync && !invOutputsEnabled
    |-> code == CODE_TWO)
    else $error("disabled outputs not shown as two blinks");
  steadyLink_a: assert property ( // RL4
    clkEn && linkFault && pwSync != 4'h0 |=> sysFaultIndicator)
    else $error("indicator not steady on link loss");
  steadyMaint_a: assert property ( // RL5
    clkEn && maintSync && pwSync != 4'h0 |=> sysFaultIndicator)
    else $error("indicator not steady with maintenance switch off");
  fault91_a: assert property ( // RL6
    clkEn && linkFault |=> diagFaultCode == 8'd91
      && processInputWordOne[15:8] == 8'd91)
    else $error("fault code 91 not reported");
  linkClear_a: assert property ( // RL7
    clkEn && linkUp |=> !linkFault)
    else $error("link fault did not clear");
  resetIgnored_a: assert property ( // RL7
    clkEn && !linkUp && ctrlResetReq |=> linkFault ##0 clkEn
      |=> !inverterResetReq)
    else $error("reset acted on link fault");
  fixedWords_a: assert property ( // RL8
    clkEn && linkFault |=> processInputWordOne == 16'h5b20
      && processInputWordTwo == 16'h0000
      && processInputWordThree == 16'h0020
      && processInputWordThree[MALFUNC_POS]
      && processInputWordOne[MALFUNC_POS])
    else $error("substitute words wrong");
  diUpdate_a: assert property ( // RL10
    !rst && clkEn ##1 clkEn ##1 clkEn
      |=> digitalInputByte == $past(digitalInputPins, 3))
    else $error("digital inputs not updated");
  timeoutFire_a: assert property ( // RL12
    $rose(busTimeout) |-> $past(tmoCnt) >= 18'(4 * $past(expectedPacketRate))
      && $past(expectedPacketRate) != 16'h0000)
    else $error("timeout fired early");
  zeroOff_a: assert property ( // RL13
    expectedPacketRate == 16'h0000 && !busTimeout |=> !busTimeout)
    else $error("timeout fired while disabled");
  eprTake_a: assert property ( // RL14
    clkEn && eprWrite && eprClass == 8'h05 && eprAttr == 8'h09
      && eprValue % 16'd5 == 16'h0000
    |=> expectedPacketRate == $past(eprValue) && eprAck)
    else $error("packet rate write not taken");
  muteDark_a: assert property ( // RL15
    clkEn && pwSync == 4'h0 |=> !sysFaultIndicator)
    else $error("indicator lit with no process words");
  rejectKeep_a: assert property ( // RL13
    clkEn && eprWrite && eprValue % 16'd5 != 16'h0000
    |=> eprReject && !eprAck && $stable(expectedPacketRate))
    else $error("bad packet rate not refused");
  timeoutLate_a: assert property ( // RL12
    clkEn && expectedPacketRate != 16'h0000 && !busTimeout
      && tmoCnt >= 18'(4 * expectedPacketRate)
    |=> busTimeout)
    else $error("timeout fired late");
  freezeHold_a: assert property ( // RL7
    !clkEn |=> $stable(linkFault) && $stable(processInputWordOne))
    else $error("state moved while clock enable low");
  wordPass_a: assert property ( // RL2
    clkEn && !linkFault |=> processInputWordOne == $past(invWordOne))
    else $error("inverter status word not passed on");

  linkLoss_c: cover property ($rose(linkFault));
  twoBlink_c: cover property (code == CODE_TWO ##1 sysFaultIndicator);
  timeout_c: cover property ($rose(busTimeout));
  reject_c: cover property (eprReject);
endmodule : fgw_fault_status
`default_nettype wire

// ### testbench/fgw_inverter_model.sv
`timescale 1ns/1ps
`default_nettype none
module fgw_inverter_model
  import fgw_pkg::*;
#(
  parameter logic [3:0] SERIAL_ADDR = 4'h1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Scenario control
  input wire logic linkOn,
  input wire logic faultOn,
  input wire logic outEnOn,
  input wire logic [15:0] statusWord,
  // Serial link receiver side
  output logic linkUp,
  output logic invFault,
  output logic invOutputsEnabled,
  output logic [15:0] invWordOne,
  output logic [15:0] invWordTwo,
  output logic [15:0] invWordThree
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      linkUp <= 1'b0;
      invFault <= 1'b0;
      invOutputsEnabled <= 1'b0;
      invWordOne <= 16'h0000;
      invWordTwo <= 16'h0000;
      invWordThree <= 16'h0000;
    end else if (linkOn) begin
      linkUp <= 1'b1;
      invFault <= faultOn;
      invOutputsEnabled <= outEnOn && (SERIAL_ADDR == 4'h1);
      invWordOne <= statusWord;
      invWordTwo <= 16'h0123;
      invWordThree <= 16'h0004;
    end else begin
      // Dead link: stale data churns so none of it can leak through
      linkUp <= 1'b0;
      invFault <= ~invFault;
      invWordOne <= ~invWordOne;
      invWordTwo <= ~invWordTwo;
      invWordThree <= ~invWordThree;
    end
  end
endmodule : fgw_inverter_model
`default_nettype wire

// ### testbench/tb_fgw_fault_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fgw_fault_status;
  import fgw_pkg::*;
  typedef struct {
    logic link;
    logic flt;
    logic [15:0] w1;
    logic [7:0] din;
    logic [15:0] eW1, eW2, eW3;
    logic [7:0] eDiag;
  } fgw_row_s;
  logic ref_clk = 1'b0, rst = 1'b1, clkEn = 1'b1;
  logic linkOn = 1'b1, faultOn = 1'b0, outEnOn = 1'b1;
  logic [15:0] statusWord = 16'h0007;
  logic linkUp, invFault, invOutputsEnabled;
  logic [15:0] invWordOne, invWordTwo, invWordThree;
  logic maintSwitchOff = 1'b0, ctrlResetReq = 1'b0, packetRx = 1'b0;
  logic [7:0] digitalInputPins = 8'h00;
  logic [3:0] processWords = 4'h3;
  logic eprWrite = 1'b0;
  logic [7:0] eprClass = 8'h00, eprAttr = 8'h00;
  logic [15:0] eprValue = 16'h0000;
  logic sysFaultIndicator, linkFault, inverterResetReq;
  logic [15:0] processInputWordOne, processInputWordTwo;
  logic [15:0] processInputWordThree, expectedPacketRate;
  logic [7:0] digitalInputByte, diagFaultCode;
  logic eprAck, eprReject, busTimeout;
  int n_errors = 0, total_checks = 0, n, lit, blinks;
  fgw_row_s rows [5] = '{
    '{1'b1, 1'b0, 16'h0007, 8'ha5, 16'h0007, 16'h0123, 16'h0004, 8'h00},
    '{1'b1, 1'b1, 16'h1a05, 8'h3c, 16'h1a05, 16'h0123, 16'h0004, 8'h1a},
    '{1'b0, 1'b0, 16'h0007, 8'h5a, 16'h5b20, 16'h0000, 16'h0020, 8'd91},
    '{1'b0, 1'b0, 16'h0007, 8'hc3, 16'h5b20, 16'h0000, 16'h0020, 8'd91},
    '{1'b1, 1'b0, 16'h0007, 8'h0f, 16'h0007, 16'h0123, 16'h0004, 8'h00}};

  always #5 ref_clk = ~ref_clk;

  fgw_inverter_model inv (.ref_clk(ref_clk), .rst(rst), .linkOn(linkOn),
    .faultOn(faultOn), .outEnOn(outEnOn), .statusWord(statusWord),
    .linkUp(linkUp), .invFault(invFault),
    .invOutputsEnabled(invOutputsEnabled), .invWordOne(invWordOne),
    .invWordTwo(invWordTwo), .invWordThree(invWordThree));

  // Short ms tick keeps blink and timeout runs inside budget
  fgw_fault_status #(.MS_TICKS(4)) DUT (.ref_clk(ref_clk), .rst(rst),
    .clkEn(clkEn), .linkUp(linkUp), .invFault(invFault),
    .invOutputsEnabled(invOutputsEnabled), .invWordOne(invWordOne),
    .invWordTwo(invWordTwo), .invWordThree(invWordThree),
    .maintSwitchOff(maintSwitchOff), .digitalInputPins(digitalInputPins),
    .processWords(processWords), .ctrlResetReq(ctrlResetReq),
    .packetRx(packetRx), .eprWrite(eprWrite), .eprClass(eprClass),
    .eprAttr(eprAttr), .eprValue(eprValue),
    .sysFaultIndicator(sysFaultIndicator),
    .processInputWordOne(processInputWordOne),
    .processInputWordTwo(processInputWordTwo),
    .processInputWordThree(processInputWordThree),
    .digitalInputByte(digitalInputByte), .diagFaultCode(diagFaultCode),
    .linkFault(linkFault), .inverterResetReq(inverterResetReq),
    .eprAck(eprAck), .eprReject(eprReject),
    .expectedPacketRate(expectedPacketRate), .busTimeout(busTimeout));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic litCount(input int cycles);
    lit = 0;
    repeat (cycles) begin
      @(posedge ref_clk);
      #1;
      if (sysFaultIndicator === 1'b1) lit++;
    end
  endtask : litCount

  // Waits out any running code, then counts blinks of one whole cycle
  task automatic countBlinks;
    int dark;
    int guard;
    dark = 0;
    guard = 0;
    blinks = 0;
    while (dark < 2000 && guard < 30000) begin
      @(posedge ref_clk);
      #1;
      guard++;
      dark = (sysFaultIndicator === 1'b0) ? dark + 1 : 0;
    end
    dark = 0;
    while ((blinks == 0 || dark < 2000) && guard < 30000) begin
      @(posedge ref_clk);
      #1;
      guard++;
      if (sysFaultIndicator === 1'b1 && dark > 0) blinks++;
      dark = (sysFaultIndicator === 1'b0) ? dark + 1 : 0;
    end
    if (guard >= 30000) begin
      n_errors++;
      stop_test();
    end
  endtask : countBlinks

  task automatic eprWr(input logic [7:0] cls, input logic [7:0] attr,
      input logic [15:0] val, input logic expAck, input logic [15:0] rate);
    @(posedge ref_clk);
    eprWrite <= 1'b1;
    eprClass <= cls;
    eprAttr <= attr;
    eprValue <= val;
    @(posedge ref_clk);
    eprWrite <= 1'b0;
    #1;
    check(16'(eprAck), 16'(expAck));
    check(16'(eprReject), 16'(!expAck));
    check(expectedPacketRate, rate);
  endtask : eprWr

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      linkOn <= rows[i].link;
      faultOn <= rows[i].flt;
      statusWord <= rows[i].w1;
      digitalInputPins <= rows[i].din;
      repeat (8) @(posedge ref_clk);
      #1;
      check(processInputWordOne, rows[i].eW1);
      check(processInputWordTwo, rows[i].eW2);
      check(processInputWordThree, rows[i].eW3);
      check(16'(diagFaultCode), 16'(rows[i].eDiag));
      check(16'(digitalInputByte), 16'(rows[i].din));
      check(16'(linkFault), 16'(!rows[i].link));
    end
    $display("test words done");
    litCount(3000);
    check(16'(lit), 16'h0000);
    faultOn <= 1'b1;
    countBlinks();
    check(16'(blinks), 16'h0001);
    faultOn <= 1'b0;
    outEnOn <= 1'b0;
    countBlinks();
    check(16'(blinks), 16'h0002);
    $display("test blink codes done");
    @(posedge ref_clk);
    maintSwitchOff <= 1'b1;
    repeat (10) @(posedge ref_clk);
    litCount(500);
    check(16'(lit), 16'd500);
    @(posedge ref_clk);
    processWords <= 4'h0;
    repeat (10) @(posedge ref_clk);
    litCount(500);
    check(16'(lit), 16'h0000);
    @(posedge ref_clk);
    processWords <= 4'h3;
    maintSwitchOff <= 1'b0;
    outEnOn <= 1'b1;
    linkOn <= 1'b0;
    ctrlResetReq <= 1'b1;
    repeat (10) @(posedge ref_clk);
    litCount(500);
    check(16'(lit), 16'd500);
    check(16'(inverterResetReq), 16'h0000);
    check(16'(linkFault), 16'h0001);
    linkOn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(16'(linkFault), 16'h0000);
    check(16'(inverterResetReq), 16'h0001);
    @(posedge ref_clk);
    ctrlResetReq <= 1'b0;
    $display("test steady and reset done");
    eprWr(8'h05, 8'h09, 16'd5, 1'b1, 16'd5);
    n = 0;
    while (busTimeout !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(16'(n >= 76 && n <= 84), 16'h0001);
    if (n >= 200) stop_test();
    @(posedge ref_clk);
    packetRx <= 1'b1;
    @(posedge ref_clk);
    packetRx <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(16'(busTimeout), 16'h0000);
    eprWr(8'h05, 8'h09, 16'd7, 1'b0, 16'd5);
    eprWr(8'h05, 8'h0a, 16'd10, 1'b0, 16'd5);
    eprWr(8'h04, 8'h09, 16'd10, 1'b0, 16'd5);
    eprWr(8'h05, 8'h09, 16'd65535, 1'b1, 16'd65535);
    eprWr(8'h05, 8'h09, 16'd0, 1'b1, 16'd0);
    repeat (300) @(posedge ref_clk);
    #1;
    check(16'(busTimeout), 16'h0000);
    $display("test packet rate done");
    @(posedge ref_clk);
    clkEn <= 1'b0;
    linkOn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    check(16'(linkFault), 16'h0000);
    check(processInputWordOne, 16'h0007);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    check(16'(linkFault), 16'h0001);
    check(16'(sysFaultIndicator), 16'h0001);
    $display("test clock enable done");
    // Mid-run reset with word one, diag code, indicator and input byte away from zero
    @(posedge ref_clk);
    rst <= 1'b1;
    linkOn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(processInputWordOne, 16'h0000);
    check(16'(diagFaultCode), 16'h0000);
    check(16'(sysFaultIndicator), 16'h0000);
    check(16'(digitalInputByte), 16'h0000);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    check(processInputWordOne, 16'h0007);
    check(16'(linkFault), 16'h0000);
    check(16'(digitalInputByte), 16'h000f);
    check(16'(sysFaultIndicator), 16'h0000);
    $display("test reset done");
    stop_test();
  end
endmodule : tb_fgw_fault_status
`default_nettype wire
